/* hw/ocs_defines.svh */
// Constants of the oscillator and system clock control block.
// Assumes an 8-bit register port and a 20 MHz control clock.
`ifndef OCS_DEFINES_SVH
`define OCS_DEFINES_SVH

// ============================================================
// Register offsets
`define OCS_ADDR_CLKMD      8'h03
`define OCS_ADDR_XTAL       8'h0a
`define OCS_ADDR_TRIM       8'h0b
`define OCS_ADDR_STAT       8'h0c

// ============================================================
// Field positions
`define OCS_XTAL_EN_BIT     7
`define OCS_CAPI_MSB        4
`define OCS_CAPI_LSB        3
`define OCS_CAPO_MSB        2
`define OCS_CAPO_LSB        1
`define OCS_FAST_EN_BIT     4
`define OCS_SLOW_EN_BIT     2

// ============================================================
// Reset and boot values
`define OCS_XTAL_RST        8'h00
`define OCS_TRIM_RST        8'h80
`define OCS_CLKMD_RST_SLOW  8'hf4
`define OCS_CLKMD_RST_DIV64 8'h54
`define OCS_CLKMD_DIV2      8'h34
`define OCS_CLKMD_DIV4      8'h14
`define OCS_CLKMD_DIV8      8'h3c
`define OCS_CLKMD_DIV16     8'h1c
`define OCS_CLKMD_DIV32     8'h7c
`define OCS_CLKMD_SLOW      8'he4

// ============================================================
// Boot delays, counted in slow RC oscillator cycles; the settle count is in control clock cycles
`define OCS_BOOT_FAST_CYC   12'd45
`define OCS_BOOT_SLOW_CYC   12'd3000
`define OCS_SETTLE_CYC      2'd3

`endif

/* hw/ocs_div.sv */
// Power-of-two divider on source ticks, emitting a one-cycle pulse.
// Assumes ticks at most once per control clock cycle.
`default_nettype none

module ocs_div
    import ocs_pkg::*;
(
    input  wire logic       clk_in,        // Control clock.
    input  wire logic       rst_b_in,      // Async reset, active low.
    input  wire logic       tick_in,       // Selected source edge.
    input  wire logic       restart_in,    // Start a fresh period.
    input  wire logic [2:0] div_log2_in,   // Divide by 2**div_log2, at most 64.
    output logic            pulse_out      // Divided clock pulse.
);

    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic       pulse_q;
    logic       pulse_d;
    logic [5:0] mask;

    // ========================================================
    // Divider count
    // A restart discards the partial period, so the first pulse after
    // a switch always follows 2**div_log2 whole ticks of the new source, and can come up to one source period sooner than a whole period.
    always_comb
    begin
        mask    = 6'((7'h01 << div_log2_in) - 7'h01);
        cnt_d   = cnt_q;
        pulse_d = 1'b0;
        if (restart_in)
        begin
            cnt_d = 6'h00;
        end
        else if (tick_in)
        begin
            if (cnt_q >= mask)
            begin
                cnt_d   = 6'h00;
                pulse_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt_q   <= 6'h00;
            pulse_q <= 1'b0;
        end
        else
        begin
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse_out = pulse_q;

endmodule

`default_nettype wire

/* hw/ocs_pkg.sv */
// Types shared by the oscillator and system clock control block.
// Assumes nothing of its surroundings.
`default_nettype none

package ocs_pkg;

    // ========================================================
    // Clock sources and boot states
    typedef enum logic [1:0] {SRC_FAST, SRC_SLOW, SRC_XTAL} ocs_src_t;

    typedef enum logic [1:0] {BOOT_SETTLE, BOOT_WAIT, BOOT_RUN} ocs_boot_t;

    // ========================================================
    // Carriers
    typedef struct packed {
        ocs_src_t   src;
        logic [2:0] div_log2;
    } ocs_sel_t;

    typedef struct packed {
        logic       boot_fast;
        logic [2:0] cal_opt;
        logic [7:0] trim;
    } ocs_straps_t;

endpackage

`default_nettype wire

/* hw/ocs_sync.sv */
// Two-flop synchroniser with a rising-edge tick on bit 0.
// Assumes asynchronous inputs and one control clock.
`default_nettype none

module ocs_sync
    import ocs_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk_in,    // Control clock.
    input  wire logic         rst_b_in,  // Async reset, active low.
    input  wire logic [W-1:0] d_in,      // Asynchronous input.
    output logic      [W-1:0] q_out,     // Synchronised level.
    output logic              rise_out   // One-cycle tick on bit 0 rise.
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_q;
    logic [W-1:0] s2_d;
    logic         s3_q;
    logic         s3_d;

    // ========================================================
    // Next values
    always_comb
    begin
        s1_d = d_in;
        s2_d = s1_q;
        s3_d = s2_q[0];
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    assign q_out    = s2_q;
    assign rise_out = s2_q[0] & ~s3_q;

endmodule

`default_nettype wire

/* hw/ocs_top.sv */
// Oscillator enables, crystal load settings, trim, boot sequencing and
// system clock selection with division.
// Assumes oscillator outputs arrive as pins and a firmware register port.
`include "ocs_defines.svh"
`default_nettype none

module ocs_top
    import ocs_pkg::*;
#(
    parameter logic [11:0] BOOT_FAST_CYC = `OCS_BOOT_FAST_CYC,
    parameter logic [11:0] BOOT_SLOW_CYC = `OCS_BOOT_SLOW_CYC
)
(
    input  wire logic       CLK_IN,                 // 20 MHz clock.
    input  wire logic       RST_B_IN,               // Power-on reset.
    input  wire logic [7:0] ADDR_IN,                // Register address.
    input  wire logic [7:0] WDATA_IN,               // Write data.
    input  wire logic       WR_IN,                  // Write strobe.
    input  wire logic       RD_IN,                  // Read strobe.
    output logic      [7:0] RDATA_OUT,              // Read data.
    input  wire logic       FAST_RC_CLK_IN,         // Fast RC output.
    input  wire logic       SLOW_RC_CLK_IN,         // Slow RC output.
    input  wire logic       XTAL_CLK_IN,            // Crystal output.
    input  wire logic       BOOT_FAST_IN,           // Fast boot option.
    input  wire logic [2:0] CAL_OPT_IN,             // Calibration option.
    input  wire logic [7:0] TRIM_CAL_IN,            // Calibrated trim.
    output logic            FAST_RC_EN_OUT,         // Fast RC enable.
    output logic            SLOW_RC_EN_OUT,         // Slow RC enable.
    output logic            XTAL_EN_OUT,            // Crystal enable.
    output logic      [1:0] XTAL_CAP_IN_OUT,        // Input load code.
    output logic      [1:0] XTAL_CAP_OUT_OUT,       // Output load code.
    output logic      [7:0] FAST_RC_TRIM_OUT,       // Fast RC trim.
    output logic            SYS_CLK_EN_OUT,         // System clock pulse.
    output logic            BOOT_DONE_OUT,          // Boot complete.
    output logic            WDT_EN_OUT,             // Watchdog enable.
    output logic            PORT_A_BIT5_INPUT_OUT   // Port A bit 5 input.
);

    // ========================================================
    // Declarations
    logic        fast_rise;
    logic        slow_rise;
    logic        xtal_rise;
    ocs_straps_t straps_raw;
    ocs_straps_t straps_sync;

    ocs_boot_t   boot_q;
    ocs_boot_t   boot_d;
    logic [1:0]  settle_q;
    logic [1:0]  settle_d;
    logic [11:0] boot_cnt_q;
    logic [11:0] boot_cnt_d;
    ocs_straps_t straps_q;
    ocs_straps_t straps_d;

    logic [7:0]  clkmd_q;
    logic [7:0]  clkmd_d;
    logic [7:0]  xtal_q;
    logic [7:0]  xtal_d;
    logic [7:0]  trim_q;
    logic [7:0]  trim_d;
    logic        wdt_q;
    logic        wdt_d;
    logic        pa5_in_q;
    logic        pa5_in_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic        done_q;
    logic        done_d;

    ocs_sel_t    sel_cur;
    ocs_sel_t    sel_new;
    logic        src_tick;
    logic        div_restart;
    logic        boot_fast_end;
    logic [11:0] boot_limit;

    // ========================================================
    // Pin synchronisers
    ocs_sync #(.W(1)) u_sync_fast (
        .clk_in   (CLK_IN),
        .rst_b_in (RST_B_IN),
        .d_in     (FAST_RC_CLK_IN),
        .q_out    (),
        .rise_out (fast_rise)
    );

    ocs_sync #(.W(1)) u_sync_slow (
        .clk_in   (CLK_IN),
        .rst_b_in (RST_B_IN),
        .d_in     (SLOW_RC_CLK_IN),
        .q_out    (),
        .rise_out (slow_rise)
    );

    // The crystal path only needs edge detection; 32 kHz is far below
    // the control clock, so no higher crystal rate is catered for.
    ocs_sync #(.W(1)) u_sync_xtal (
        .clk_in   (CLK_IN),
        .rst_b_in (RST_B_IN),
        .d_in     (XTAL_CLK_IN),
        .q_out    (),
        .rise_out (xtal_rise)
    );

    assign straps_raw = '{boot_fast: BOOT_FAST_IN,
                          cal_opt:   CAL_OPT_IN,
                          trim:      TRIM_CAL_IN};

    ocs_sync #(.W(12)) u_sync_straps (
        .clk_in   (CLK_IN),
        .rst_b_in (RST_B_IN),
        .d_in     (straps_raw),
        .q_out    (straps_sync),
        .rise_out ()
    );

    // ========================================================
    // Clock mode decode
    function automatic ocs_sel_t decode(input logic [7:0] md);
        ocs_sel_t s;
        s.src      = SRC_FAST;
        s.div_log2 = 3'd0;
        case ({md[7:5], md[3]})
            4'b0010: s.div_log2 = 3'd1;
            4'b0000: s.div_log2 = 3'd2;
            4'b0011: s.div_log2 = 3'd3;
            4'b0001: s.div_log2 = 3'd4;
            4'b0111: s.div_log2 = 3'd5;
            4'b0100: s.div_log2 = 3'd6;
            4'b1110: s.src = SRC_SLOW;
            4'b1010: s.src = SRC_XTAL;
            default: s.src = SRC_SLOW;
        endcase
        return s;
    endfunction

    assign sel_cur = decode(clkmd_q);
    assign sel_new = decode(clkmd_d);

    // ========================================================
    // Source gating
    // A disabled oscillator yields no ticks, so turning off the source
    // that is currently selected stops the system clock.
    always_comb
    begin
        case (sel_cur.src)
            SRC_FAST: src_tick = fast_rise & clkmd_q[`OCS_FAST_EN_BIT];
            SRC_SLOW: src_tick = slow_rise & clkmd_q[`OCS_SLOW_EN_BIT];
            SRC_XTAL: src_tick = xtal_rise & xtal_q[`OCS_XTAL_EN_BIT];
            default:  src_tick = 1'b0;
        endcase
    end

    // Selection changes restart the divider at the same edge that loads the new selection.
    assign div_restart = (sel_new != sel_cur);

    ocs_div u_div (
        .clk_in      (CLK_IN),
        .rst_b_in    (RST_B_IN),
        .tick_in     (src_tick & (boot_q == BOOT_RUN)),
        .restart_in  (div_restart),
        .div_log2_in (sel_cur.div_log2),
        .pulse_out   (SYS_CLK_EN_OUT)
    );

    // ========================================================
    // Boot sequencing and registers
    assign boot_limit = straps_q.boot_fast ? BOOT_FAST_CYC : BOOT_SLOW_CYC;
    assign boot_fast_end = (boot_q == BOOT_WAIT) && slow_rise &&
                           (boot_cnt_q >= boot_limit - 12'd1);

    always_comb
    begin
        boot_d     = boot_q;
        settle_d   = settle_q;
        boot_cnt_d = boot_cnt_q;
        straps_d   = straps_q;
        clkmd_d    = clkmd_q;
        xtal_d     = xtal_q;
        trim_d     = trim_q;
        wdt_d      = wdt_q;
        pa5_in_d   = pa5_in_q;

        if (WR_IN)
        begin
            case (ADDR_IN)
                `OCS_ADDR_CLKMD: clkmd_d = WDATA_IN;
                `OCS_ADDR_XTAL:  xtal_d  = WDATA_IN;
                `OCS_ADDR_TRIM:  trim_d  = WDATA_IN;
                default:         ;
            endcase
        end

        case (boot_q)
            BOOT_SETTLE:
            begin
                settle_d = settle_q + 2'd1;
                if (settle_q == `OCS_SETTLE_CYC)
                begin
                    straps_d   = straps_sync;
                    boot_cnt_d = 12'd0;
                    boot_d     = BOOT_WAIT;
                    clkmd_d    = straps_sync.boot_fast ?
                                 `OCS_CLKMD_RST_DIV64 : `OCS_CLKMD_RST_SLOW;
                end
            end
            BOOT_WAIT:
            begin
                if (slow_rise)
                begin
                    boot_cnt_d = boot_cnt_q + 12'd1;
                end
                if (boot_fast_end)
                begin
                    boot_d   = BOOT_RUN;
                    pa5_in_d = 1'b1;
                    wdt_d    = 1'b0;
                    trim_d   = straps_q.trim;
                    case (straps_q.cal_opt)
                        3'd1: clkmd_d = `OCS_CLKMD_DIV2;
                        3'd2: clkmd_d = `OCS_CLKMD_DIV4;
                        3'd3: clkmd_d = `OCS_CLKMD_DIV8;
                        3'd4: clkmd_d = `OCS_CLKMD_DIV16;
                        3'd5: clkmd_d = `OCS_CLKMD_DIV32;
                        3'd6: clkmd_d = `OCS_CLKMD_SLOW;
                        default:
                        begin
                            wdt_d  = 1'b1;
                            trim_d = trim_q;
                        end
                    endcase
                end
            end
            BOOT_RUN: ;
            default:  boot_d = BOOT_SETTLE;
        endcase
        done_d = (boot_d == BOOT_RUN);
    end

    // ========================================================
    // Read port
    always_comb
    begin
        rdata_d = 8'h00;
        if (RD_IN)
        begin
            case (ADDR_IN)
                `OCS_ADDR_CLKMD: rdata_d = clkmd_q;
                `OCS_ADDR_XTAL:  rdata_d = {xtal_q[7], 2'b00, xtal_q[4:1],
                                            1'b0};
                `OCS_ADDR_TRIM:  rdata_d = trim_q;
                `OCS_ADDR_STAT:  rdata_d = {1'b0, sel_cur.div_log2, wdt_q,
                                            boot_q == BOOT_RUN,
                                            2'(sel_cur.src)};
                default:         rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            boot_q     <= BOOT_SETTLE;
            settle_q   <= 2'd0;
            boot_cnt_q <= 12'd0;
            straps_q   <= '0;
            clkmd_q    <= `OCS_CLKMD_RST_SLOW;
            xtal_q     <= `OCS_XTAL_RST;
            trim_q     <= `OCS_TRIM_RST;
            wdt_q      <= 1'b1;
            pa5_in_q   <= 1'b1;
            rdata_q    <= 8'h00;
            done_q     <= 1'b0;
        end
        else
        begin
            boot_q     <= boot_d;
            settle_q   <= settle_d;
            boot_cnt_q <= boot_cnt_d;
            straps_q   <= straps_d;
            clkmd_q    <= clkmd_d;
            xtal_q     <= xtal_d;
            trim_q     <= trim_d;
            wdt_q      <= wdt_d;
            pa5_in_q   <= pa5_in_d;
            rdata_q    <= rdata_d;
            done_q     <= done_d;
        end
    end

    // ========================================================
    // Outputs
    assign RDATA_OUT             = rdata_q;
    assign FAST_RC_EN_OUT        = clkmd_q[`OCS_FAST_EN_BIT];
    assign SLOW_RC_EN_OUT        = clkmd_q[`OCS_SLOW_EN_BIT];
    assign XTAL_EN_OUT           = xtal_q[`OCS_XTAL_EN_BIT];
    assign XTAL_CAP_IN_OUT       = xtal_q[`OCS_CAPI_MSB:`OCS_CAPI_LSB];
    assign XTAL_CAP_OUT_OUT      = xtal_q[`OCS_CAPO_MSB:`OCS_CAPO_LSB];
    assign FAST_RC_TRIM_OUT      = trim_q;
    assign BOOT_DONE_OUT         = done_q;
    assign WDT_EN_OUT            = wdt_q;
    assign PORT_A_BIT5_INPUT_OUT = pa5_in_q;

endmodule

`default_nettype wire

/* test/ocs_top_bench.sv */
// Self-checking bench for the oscillator and system clock control block.
// Assumes ocs_top, its package and the checker are compiled before it.
`include "ocs_defines.svh"
`default_nettype none

module ocs_top_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk_in = 1'b0;
    logic       rst_b  = 1'b0;
    logic [7:0] addr   = 8'h00;
    logic [7:0] wdata  = 8'h00;
    logic       wr     = 1'b0;
    logic       rd     = 1'b0;
    logic       bfast  = 1'b0;
    logic [2:0] cal    = 3'h0;
    logic [7:0] tcal   = 8'h00;
    logic [3:0] ph     = 4'h0;
    logic [3:0] xc     = 4'h0;
    logic [7:0] rdata, trim;
    logic       fen, sen, xen, sys, done, wdt, pa5;
    logic [1:0] capi, capo;
    int         fail_count = 0;
    int         checked    = 0;
    int         nb;
    logic [7:0] md_seq [10] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c,
                                8'h54, 8'hf4, 8'he4, 8'hf4, 8'h34};
    int         per_seq [10] = '{8, 16, 32, 64, 128, 256, 16, 16, 16, 8};
    int         src_seq [10] = '{4, 4, 4, 4, 4, 4, 16, 16, 16, 4};

    always #25 clk_in = ~clk_in;

    // ========================================================
    // Oscillator stand-ins: fast period 4, slow 16, crystal 12 cycles.
    always @(posedge clk_in)
    begin
        ph <= ph + 4'h1;
        xc <= (xc == 4'hb) ? 4'h0 : xc + 4'h1;
    end

    ocs_top #(.BOOT_FAST_CYC(12'h004), .BOOT_SLOW_CYC(12'h008)) i_ocs_top (
        .CLK_IN(clk_in), .RST_B_IN(rst_b), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .FAST_RC_CLK_IN(ph[1]), .SLOW_RC_CLK_IN(ph[3]),
        .XTAL_CLK_IN(xc < 4'h6), .BOOT_FAST_IN(bfast),
        .CAL_OPT_IN(cal), .TRIM_CAL_IN(tcal), .FAST_RC_EN_OUT(fen),
        .SLOW_RC_EN_OUT(sen), .XTAL_EN_OUT(xen), .XTAL_CAP_IN_OUT(capi),
        .XTAL_CAP_OUT_OUT(capo), .FAST_RC_TRIM_OUT(trim),
        .SYS_CLK_EN_OUT(sys), .BOOT_DONE_OUT(done), .WDT_EN_OUT(wdt),
        .PORT_A_BIT5_INPUT_OUT(pa5));

    // ========================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
        @(negedge clk_in);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        d = rdata;
    endtask

    task automatic wait_pulse(output int n);
        n = 0;
        do
        begin
            @(negedge clk_in);
            n++;
        end
        while (sys !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            chk(16'(n), 16'h0);
            wrap_up();
        end
    endtask

    task automatic boot(input logic bf, input logic [2:0] c,
                        input logic [7:0] t, output int n);
        n = 0;
        @(posedge clk_in);
        rst_b <= 1'b0;
        bfast <= bf;
        cal   <= c;
        tcal  <= t;
        repeat (10) @(posedge clk_in);
        rst_b <= 1'b1;
        while (done !== 1'b1 && n < 2000)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 2000)
        begin
            chk(16'(n), 16'h0);
            wrap_up();
        end
    endtask

    // ========================================================
    // Scenarios
    task automatic test_boot();
        logic [7:0] tab [8] = '{8'hf4, 8'h34, 8'h14, 8'h3c,
                                8'h1c, 8'h7c, 8'he4, 8'hf4};
        logic [7:0] md;
        logic       un;
        int         n, lim;
        for (int c = 0; c < 8; c++)
        begin
            un  = (c == 0 || c == 7);
            lim = c[0] ? 4 : 8;
            boot(c[0], c[2:0], 8'h40 + 8'(c), n);
            chk(16'(n >= (lim - 1) * 16 && n <= lim * 16 + 24), 16'h1);
            rd_reg(`OCS_ADDR_CLKMD, md);
            chk(md, (un && c[0]) ? 8'h54 : tab[c]);
            chk({wdt, pa5, sen, fen}, {un, 2'b11, c != 6});
            chk(trim, un ? 8'h80 : 8'h40 + 8'(c));
        end
        $display("boot options done");
    endtask

    task automatic test_regs();
        logic [7:0] d, r;
        for (int i = 0; i < 4; i++)
        begin
            d = {i[0], 2'b11, i[1:0], ~i[1:0], 1'b1};
            wr_reg(`OCS_ADDR_XTAL, d);
            chk({xen, capi, capo}, {i[0], i[1:0], ~i[1:0]});
            rd_reg(`OCS_ADDR_XTAL, r);
            chk(r, d & 8'h9e);
        end
        wr_reg(`OCS_ADDR_TRIM, 8'h5a);
        rd_reg(`OCS_ADDR_TRIM, r);
        chk({trim, r}, 16'h5a5a);
        wr_reg(8'h20, 8'hff);
        rd_reg(8'h20, r);
        chk(r, 8'h00);
        rd_reg(`OCS_ADDR_XTAL, r);
        chk(r, 8'h98);
        wr_reg(`OCS_ADDR_XTAL, 8'h00);
        $display("register access done");
    endtask

    task automatic clk_case(input logic [7:0] md, input int per,
                            input int sp);
        logic [7:0] st;
        int         n1, n2;
        wr_reg(`OCS_ADDR_CLKMD, md);
        chk({fen, sen}, {md[4], md[2]});
        rd_reg(`OCS_ADDR_STAT, st);
        chk(st[2:0], {1'b1, !md[7] ? 2'h0 : (md[6] ? 2'h1 : 2'h2)});
        wait_pulse(n1);
        wait_pulse(n2);
        chk(16'(n1 + 4 >= per - sp), 16'h1);
        chk(16'(n2), 16'(per));
        $display("clock mode %h done", md);
    endtask

    task automatic test_stop();
        int n;
        wr_reg(`OCS_ADDR_XTAL, 8'h00);
        repeat (4) @(negedge clk_in);
        n = 0;
        repeat (60)
        begin
            @(negedge clk_in);
            n += int'(sys === 1'b1);
        end
        chk(16'(n), 16'h0);
        $display("stopped source done");
    endtask

    initial
    begin
        test_boot();
        boot(1'b0, 3'h2, 8'h77, nb);
        test_regs();
        for (int i = 0; i < 10; i++)
            clk_case(md_seq[i], per_seq[i], src_seq[i]);
        wr_reg(`OCS_ADDR_XTAL, 8'h80);
        repeat (48) @(negedge clk_in);
        clk_case(8'hb0, 12, 12);
        clk_case(8'ha0, 12, 12);
        test_stop();
        wrap_up();
    end
endmodule

`default_nettype wire

/* test/ocs_top_props.sv */
// Concurrent checks on the ports of the clock control block.
// Assumes it is bound to ocs_top and sees only that module's ports.
`default_nettype none

module ocs_top_props
    import ocs_pkg::*;
#(
    parameter logic [11:0] BOOT_FAST_CYC = 12'h02d,
    parameter logic [11:0] BOOT_SLOW_CYC = 12'hbb8
)
(
    input wire logic       CLK_IN,                 // Clock.
    input wire logic       RST_B_IN,               // Reset.
    input wire logic [7:0] ADDR_IN,                // Address.
    input wire logic [7:0] WDATA_IN,               // Write data.
    input wire logic       WR_IN,                  // Write strobe.
    input wire logic       RD_IN,                  // Read strobe.
    input wire logic [7:0] RDATA_OUT,              // Read data.
    input wire logic       FAST_RC_CLK_IN,         // Fast RC.
    input wire logic       SLOW_RC_CLK_IN,         // Slow RC.
    input wire logic       XTAL_CLK_IN,            // Crystal.
    input wire logic       BOOT_FAST_IN,           // Boot option.
    input wire logic [2:0] CAL_OPT_IN,             // Calibration.
    input wire logic [7:0] TRIM_CAL_IN,            // Boot trim.
    input wire logic       FAST_RC_EN_OUT,         // Fast enable.
    input wire logic       SLOW_RC_EN_OUT,         // Slow enable.
    input wire logic       XTAL_EN_OUT,            // Crystal enable.
    input wire logic [1:0] XTAL_CAP_IN_OUT,        // Input load.
    input wire logic [1:0] XTAL_CAP_OUT_OUT,       // Output load.
    input wire logic [7:0] FAST_RC_TRIM_OUT,       // Trim.
    input wire logic       SYS_CLK_EN_OUT,         // Clock pulse.
    input wire logic       BOOT_DONE_OUT,          // Boot done.
    input wire logic       WDT_EN_OUT,             // Watchdog.
    input wire logic       PORT_A_BIT5_INPUT_OUT   // Pin input.
);
    // ========================================================
    // Assertions
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    logic uncal;
    assign uncal = (CAL_OPT_IN == 3'h0) || (CAL_OPT_IN == 3'h7);

    AST_XTAL_EN: assert property (
        $past(WR_IN) && $past(ADDR_IN) == 8'h0a
        |-> XTAL_EN_OUT == $past(WDATA_IN[7]))
        else $error("crystal enable does not follow write");
    AST_XTAL_CAPS: assert property (
        $past(WR_IN) && $past(ADDR_IN) == 8'h0a
        |-> XTAL_CAP_IN_OUT == $past(WDATA_IN[4:3])
            && XTAL_CAP_OUT_OUT == $past(WDATA_IN[2:1]))
        else $error("load codes do not follow write");
    AST_XTAL_HOLD: assert property (
        !($past(WR_IN) && $past(ADDR_IN) == 8'h0a)
        |-> $stable({XTAL_EN_OUT, XTAL_CAP_IN_OUT, XTAL_CAP_OUT_OUT}))
        else $error("crystal settings changed without a write");
    AST_RC_ENABLES: assert property (
        $past(WR_IN) && $past(ADDR_IN) == 8'h03 && $past(BOOT_DONE_OUT)
        |-> FAST_RC_EN_OUT == $past(WDATA_IN[4])
            && SLOW_RC_EN_OUT == $past(WDATA_IN[2]))
        else $error("oscillator enables do not follow write");
    AST_BOOT_QUIET: assert property (
        SYS_CLK_EN_OUT |-> $past(BOOT_DONE_OUT))
        else $error("system clock pulse before boot end");
    AST_NO_RUNT: assert property (
        $past(WR_IN) && $past(ADDR_IN) == 8'h03 && !$past(WDATA_IN[7])
        && $past(BOOT_DONE_OUT) |-> ##1 !SYS_CLK_EN_OUT [*2])
        else $error("short clock period after a switch");
    AST_PULSE_SINGLE: assert property (
        SYS_CLK_EN_OUT |=> !SYS_CLK_EN_OUT)
        else $error("system clock pulse wider than one cycle");
    AST_BOOT_STATE: assert property (
        $rose(BOOT_DONE_OUT) |-> PORT_A_BIT5_INPUT_OUT && SLOW_RC_EN_OUT
            && FAST_RC_EN_OUT == (CAL_OPT_IN != 3'h6))
        else $error("oscillator or pin state wrong at boot end");
    AST_BOOT_WDT: assert property (
        $rose(BOOT_DONE_OUT) |-> WDT_EN_OUT == uncal)
        else $error("watchdog state wrong at boot end");
    AST_BOOT_TRIM: assert property (
        $rose(BOOT_DONE_OUT)
        |-> FAST_RC_TRIM_OUT == (uncal ? 8'h80 : TRIM_CAL_IN))
        else $error("trim value wrong at boot end");

    COV_BOOT: cover property ($rose(BOOT_DONE_OUT));
    COV_PULSE: cover property (SYS_CLK_EN_OUT);
    COV_XTAL: cover property (XTAL_EN_OUT && SYS_CLK_EN_OUT);
endmodule

bind ocs_top ocs_top_props #(
    .BOOT_FAST_CYC(BOOT_FAST_CYC),
    .BOOT_SLOW_CYC(BOOT_SLOW_CYC)
) i_ocs_top_props (.*);

`default_nettype wire
